/* core/wwd_pkg.sv */
package wwd_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int          ADDR_W    = 14;
    localparam logic [11:0] IDX_CTRL0 = 12'h80c;
    localparam logic [11:0] IDX_CTRL1 = 12'h80d;
    localparam logic [11:0] IDX_PSL   = 12'h80e;
    localparam logic [11:0] IDX_PSH   = 12'h80f;
    localparam logic [11:0] IDX_TMR   = 12'h810;
    localparam logic [11:0] IDX_CAUSE = 12'h811;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL0_ON_BIT  = 0;
    localparam int CTRL0_PS_LSB  = 1;
    localparam int CTRL1_WIN_LSB = 0;
    localparam int CTRL1_CS_LSB  = 4;
    localparam int TMR_ARM_BIT   = 2;
    localparam int TMR_WIN_LSB   = 3;
    localparam int CAUSE_WV_BIT  = 0;
    localparam int CAUSE_RW_BIT  = 1;
    localparam int CAUSE_TO_BIT  = 2;
    localparam int CAUSE_SLP_BIT = 3;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF     = 2'h0;
    localparam logic [1:0] MODE_SW      = 2'h1;
    localparam logic [1:0] MODE_NOSLEEP = 2'h2;
    localparam logic [1:0] MODE_ON      = 2'h3;
    localparam logic [4:0] PS_SW_SEL    = 5'h1f;
    localparam logic [4:0] PS_DEFAULT   = 5'h0b;
    localparam logic [4:0] PS_MAX       = 5'h12;
    localparam logic [4:0] PS_MIN       = 5'h00;
    localparam logic [2:0] CS_SW_SEL    = 3'h7;
    localparam logic [2:0] CS_LF        = 3'h0;
    localparam logic [2:0] CS_MF        = 3'h1;
    localparam logic [2:0] WIN_SW_SEL   = 3'h7;
    localparam logic [2:0] WIN_FULL     = 3'h7;

    // ------------------------------------------------------------
    // Timing: the shortest period is 2**PS_BASE_LOG2 oscillator
    // ticks, 1 ms at the nominal low-frequency rate.
    // ------------------------------------------------------------
    localparam int LF_OSC_HZ    = 31000;
    localparam int MF_OSC_HZ    = 31250;
    localparam int PS_BASE_LOG2 = 5;
    localparam int CNT_W        = 23;

    typedef enum logic [2:0] {
        WWD_OFF  = 3'b001,
        WWD_HOLD = 3'b010,
        WWD_RUN  = 3'b100
    } wwd_state_t;

endpackage

/* core/wwd_top.sv */
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module wwd_top (
    // Clock, reset, enable
    input  wire logic                       core_clk,
    input  wire logic                       srst,
    input  wire logic                       ce,
    input  wire logic                       por,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [wwd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Configuration straps
    input  wire logic [1:0]                 watchdog_mode_cfg,
    input  wire logic [4:0]                 cfg_prescale_sel,
    input  wire logic [2:0]                 cfg_clock_sel,
    input  wire logic [2:0]                 cfg_window_sel,
    // Oscillator pins
    input  wire logic                       low_freq_osc,
    input  wire logic                       mid_freq_osc,
    // Core side
    input  wire logic                       clear_command,
    input  wire logic                       arm_read,
    input  wire logic                       sleep_active,
    input  wire logic                       osc_startup_timer,
    input  wire logic                       osc_fail,
    output logic                            wdt_reset_req,
    output logic                            wake_req,
    output logic                            timeout_n_flag,
    output logic                            powerdown_n_flag
);
    import wwd_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       lf_sync;
        logic [2:0]       mf_sync;
        logic             lf_lvl;
        logic             mf_lvl;
        logic             sleep;
        wwd_state_t       fsm;
        logic [CNT_W-1:0] cnt;
        logic             sw_on;
        logic [4:0]       ps;
        logic [2:0]       cs;
        logic [2:0]       win;
        logic             armed;
        logic             wv_n;
        logic             rw_n;
        logic             to_n;
        logic             slp_n;
        logic             rst_req;
        logic             wake;
        logic [31:0]      rdata;
        logic             slverr;
    } wwd_st_t;

    wwd_st_t          st_q;
    wwd_st_t          st_d;
    logic             lf_tick;
    logic             mf_tick;
    logic             tick;
    logic [2:0]       cs_eff;
    logic [4:0]       ps_eff;
    logic [4:0]       ps_n;
    logic [2:0]       win_eff;
    logic             active;
    logic             windowed;
    logic [4:0]       msbs;
    logic             open_w;
    logic [CNT_W-1:0] mask;
    logic             terminal;
    logic [11:0]      idx;
    logic             hit;
    logic             acc;
    logic             ctrl_wr;
    logic             sleep_edge;
    logic             hold;
    logic             bad_clear;
    logic [31:0]      rmux;

    // ------------------------------------------------------------
    // Selection and window decode
    // ------------------------------------------------------------
    always_comb begin
        cs_eff = watchdog_mode_cfg[1] ? cfg_clock_sel : st_q.cs;
        ps_eff = (cfg_prescale_sel == PS_SW_SEL) ? st_q.ps
                                                 : cfg_prescale_sel;
        ps_n = (ps_eff > PS_MAX) ? PS_MIN : ps_eff;
        win_eff = (cfg_window_sel == WIN_SW_SEL) ? st_q.win
                                                 : cfg_window_sel;
        windowed = (win_eff != WIN_FULL);
        // Period is 2**(ps+5) ticks; the top five bits are the window.
        mask = ~({CNT_W{1'b1}} << (ps_n + 5'(PS_BASE_LOG2)));
        terminal = (st_q.cnt == mask);
        msbs = 5'(st_q.cnt >> ps_n);
        // open from (7 - code) * 4
        open_w = (msbs >= {~win_eff, 2'b00});
        // Reserved source codes fall back to the low-frequency clock.
        tick = (cs_eff == CS_MF) ? mf_tick : lf_tick;
        case (watchdog_mode_cfg)
            MODE_ON:      active = 1'b1;
            MODE_NOSLEEP: active = ~sleep_active;
            MODE_SW:      active = st_q.sw_on;
            default:      active = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Oscillator edge detection and bus decode
    // ------------------------------------------------------------
    // A level counts only once the second and third stages agree.
    assign lf_tick = (st_q.lf_sync[1] == st_q.lf_sync[2]) &
                     st_q.lf_sync[2] & ~st_q.lf_lvl;
    assign mf_tick = (st_q.mf_sync[1] == st_q.mf_sync[2]) &
                     st_q.mf_sync[2] & ~st_q.mf_lvl;

    assign idx     = paddr[ADDR_W-1:2];
    assign hit     = (idx >= IDX_CTRL0) && (idx <= IDX_CAUSE);
    assign acc     = psel & penable & ce;
    assign ctrl_wr = acc & pwrite & hit &
                     ((idx == IDX_CTRL0) || (idx == IDX_CTRL1));
    assign sleep_edge = sleep_active ^ st_q.sleep;
    assign hold    = ctrl_wr | sleep_edge | osc_fail | osc_startup_timer;
    assign bad_clear = windowed & ~(st_q.armed & open_w);

    always_comb begin
        rmux = 32'h0;
        case (idx)
            IDX_CTRL0: begin
                rmux[CTRL0_ON_BIT] = st_q.sw_on;
                rmux[CTRL0_PS_LSB +: 5] = ps_eff;
            end
            IDX_CTRL1: begin
                rmux[CTRL1_WIN_LSB +: 3] = win_eff;
                rmux[CTRL1_CS_LSB +: 3] = cs_eff;
            end
            IDX_PSL: rmux[7:0] = st_q.cnt[7:0] & mask[7:0];
            IDX_PSH: rmux[7:0] = st_q.cnt[15:8] & mask[15:8];
            IDX_TMR: begin
                rmux[TMR_WIN_LSB +: 5] = msbs;
                rmux[TMR_ARM_BIT] = st_q.armed;
                rmux[1:0] = st_q.cnt[17:16] & mask[17:16];
            end
            IDX_CAUSE: begin
                rmux[CAUSE_WV_BIT] = st_q.wv_n;
                rmux[CAUSE_RW_BIT] = st_q.rw_n;
                rmux[CAUSE_TO_BIT] = st_q.to_n;
                rmux[CAUSE_SLP_BIT] = st_q.slp_n;
            end
            default: rmux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rst_req = 1'b0;
        st_d.wake = 1'b0;
        st_d.lf_sync = {st_q.lf_sync[1:0], low_freq_osc};
        st_d.mf_sync = {st_q.mf_sync[1:0], mid_freq_osc};
        if (st_q.lf_sync[1] == st_q.lf_sync[2]) begin
            st_d.lf_lvl = st_q.lf_sync[2];
        end
        if (st_q.mf_sync[1] == st_q.mf_sync[2]) begin
            st_d.mf_lvl = st_q.mf_sync[2];
        end
        st_d.sleep = sleep_active;

        // Read data is captured in the setup cycle so it leaves a flop.
        if (psel & ~penable) begin
            st_d.rdata = rmux;
            st_d.slverr = ~hit;
        end
        if (acc & pwrite & hit) begin
            case (idx)
                IDX_CTRL0: begin
                    st_d.sw_on = pwdata[CTRL0_ON_BIT];
                    if (cfg_prescale_sel == PS_SW_SEL) begin
                        st_d.ps = pwdata[CTRL0_PS_LSB +: 5];
                    end
                end
                IDX_CTRL1: begin
                    if (cfg_clock_sel == CS_SW_SEL) begin
                        st_d.cs = pwdata[CTRL1_CS_LSB +: 3];
                    end
                    if (cfg_window_sel == WIN_SW_SEL) begin
                        st_d.win = pwdata[CTRL1_WIN_LSB +: 3];
                    end
                end
                IDX_CAUSE: begin
                    // Firmware may only set these; hardware clears them.
                    st_d.wv_n = st_q.wv_n | pwdata[CAUSE_WV_BIT];
                    st_d.rw_n = st_q.rw_n | pwdata[CAUSE_RW_BIT];
                    st_d.to_n = st_q.to_n | pwdata[CAUSE_TO_BIT];
                    st_d.slp_n = st_q.slp_n | pwdata[CAUSE_SLP_BIT];
                end
                default: st_d.sw_on = st_q.sw_on;
            endcase
        end

        if ((acc & ~pwrite & (idx == IDX_CTRL0)) | arm_read) begin
            st_d.armed = 1'b1;
        end

        case (st_q.fsm)
            WWD_OFF, WWD_HOLD, WWD_RUN: begin
                if (!active) begin
                    st_d.fsm = WWD_OFF;
                    st_d.cnt = '0;
                    st_d.armed = 1'b0;
                end else if (hold) begin
                    st_d.fsm = WWD_HOLD;
                    st_d.cnt = '0;
                end else begin
                    st_d.fsm = WWD_RUN;
                    if (clear_command) begin
                        st_d.cnt = '0;
                        st_d.armed = 1'b0;
                        if (bad_clear) begin
                            st_d.rst_req = 1'b1;
                            st_d.wv_n = 1'b0;
                        end
                    end else if (tick) begin
                        st_d.cnt = st_q.cnt + CNT_W'(1);
                        if (terminal) begin
                            st_d.cnt = '0;
                            st_d.armed = 1'b0;
                            st_d.to_n = 1'b0;
                            st_d.rw_n = 1'b0;
                            if (sleep_active) begin
                                st_d.wake = 1'b1;
                                st_d.slp_n = 1'b0;
                            end else begin
                                st_d.rst_req = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                st_d.fsm = WWD_OFF;
                st_d.cnt = '0;
            end
        endcase

        if (srst) begin
            st_d.fsm = WWD_OFF;
            st_d.cnt = '0;
            st_d.sw_on = 1'b0;
            st_d.armed = 1'b0;
            st_d.rst_req = 1'b0;
            st_d.wake = 1'b0;
            st_d.rdata = 32'h0;
            st_d.slverr = 1'b0;
            st_d.ps = (cfg_prescale_sel == PS_SW_SEL) ? PS_DEFAULT
                                                      : cfg_prescale_sel;
            st_d.cs = (cfg_clock_sel == CS_SW_SEL) ? CS_LF
                                                   : cfg_clock_sel;
            st_d.win = cfg_window_sel;
            if (por) begin
                st_d.wv_n = 1'b1;
                st_d.rw_n = 1'b1;
                st_d.to_n = 1'b1;
                st_d.slp_n = 1'b1;
            end
        end
    end

    // The enable freezes everything, but a reset still lands.
    always_ff @(posedge core_clk) begin
        if (ce | srst) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready  = psel & penable & ce;
    assign pslverr = pready & st_q.slverr;
    assign prdata  = st_q.rdata;
    assign wdt_reset_req    = st_q.rst_req;
    assign wake_req         = st_q.wake;
    assign timeout_n_flag   = st_q.to_n;
    assign powerdown_n_flag = st_q.slp_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_run_step;
        ce && active && !hold && st_q.fsm != WWD_OFF;
    endsequence
    sequence s_bad_clear;
        s_run_step ##0 clear_command && windowed && !st_q.armed;
    endsequence
    sequence s_timeout;
        s_run_step ##0 !clear_command && tick && terminal;
    endsequence

    off_clear_a: assert property (ce && watchdog_mode_cfg == MODE_OFF
        |=> st_q.cnt == '0 && st_q.fsm == WWD_OFF)
        else $error("watchdog not cleared while off");
    always_on_a: assert property (watchdog_mode_cfg == MODE_ON
        |-> active)
        else $error("watchdog inactive in mode 11");
    sleep_off_a: assert property (
        watchdog_mode_cfg == MODE_NOSLEEP && sleep_active |-> !active)
        else $error("watchdog active asleep in mode 10");
    sw_off_a: assert property (
        ce && watchdog_mode_cfg == MODE_SW && !st_q.sw_on |=> st_q.cnt == '0)
        else $error("software-off watchdog kept counting");
    viol_reset_a: assert property (s_bad_clear
        |=> wdt_reset_req && !st_q.wv_n ##1 !wdt_reset_req)
        else $error("unarmed clear did not cause violation");
    timeout_rst_a: assert property (s_timeout ##0 !sleep_active
        |=> wdt_reset_req && !st_q.rw_n && !wake_req)
        else $error("time-out did not request reset");
    sleep_wake_a: assert property (s_timeout ##0 sleep_active
        |=> wake_req && !wdt_reset_req && !powerdown_n_flag)
        else $error("sleep time-out did not wake");
    hold_clear_a: assert property (
        ce && osc_startup_timer [*2] |=> st_q.cnt == '0)
        else $error("counter moved during start-up");
    ctrl_wr_a: assert property (ctrl_wr && active
        |=> st_q.cnt == '0 && st_q.fsm == WWD_HOLD)
        else $error("control write did not clear counter");
    open_clear_a: assert property (
        s_run_step ##0 clear_command && !bad_clear |=> !wdt_reset_req)
        else $error("valid clear caused reset");

endmodule

`default_nettype wire

/* dv/tb_windowed_watchdog_timer.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_windowed_watchdog_timer;
    import wwd_pkg::*;
    // Code 00000 gives 32 ticks, one tick every 8 core cycles.
    localparam int PER = 256;
    logic              core_clk = 1'b0, srst = 1'b1, ce = 1'b1, por = 1'b1;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, prdata, rd;
    logic              pready, pslverr, perr;
    logic [1:0]        watchdog_mode_cfg = MODE_SW;
    logic [4:0]        cfg_prescale_sel = PS_SW_SEL;
    logic [2:0]        cfg_clock_sel = CS_SW_SEL, cfg_window_sel = WIN_SW_SEL;
    logic              low_freq_osc = 1'b0, mid_freq_osc = 1'b0;
    logic              clear_command, arm_read, sleep_active = 1'b0;
    logic              osc_startup_timer = 1'b0, osc_fail = 1'b0;
    logic              wdt_reset_req, wake_req;
    logic              timeout_n_flag, powerdown_n_flag;
    logic              req_clear = 1'b0, use_arm = 1'b0;
    logic [3:0]        gap = 4'h0, div = 4'h0;
    int                err_total = 0, tests_run = 0, t_rst, t_wake;

    always #5 core_clk = ~core_clk;

    // The two oscillators run slow, both divided from the core clock, mid_freq_osc at half the rate of low_freq_osc.
    always @(posedge core_clk) begin
        div <= div + 4'h1;
        if (div[1:0] == 2'h3) low_freq_osc <= ~low_freq_osc;
        if (div[2:0] == 3'h7) mid_freq_osc <= ~mid_freq_osc;
    end

    wwd_top dut (.core_clk, .srst, .ce, .por, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .watchdog_mode_cfg,
        .cfg_prescale_sel, .cfg_clock_sel, .cfg_window_sel, .low_freq_osc,
        .mid_freq_osc, .clear_command, .arm_read, .sleep_active,
        .osc_startup_timer, .osc_fail, .wdt_reset_req, .wake_req,
        .timeout_n_flag, .powerdown_n_flag);
    wwd_core_model core (.core_clk, .srst, .req_clear, .use_arm, .gap,
        .clear_command, .arm_read);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] idx,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            give_verdict();
        end
    endtask

    task automatic dev_reset();
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
    endtask

    // Records the cycle of the first reset pulse and of the first wake pulse, or -1 when none came.
    task automatic watch(input int cyc);
        t_rst = -1;
        t_wake = -1;
        for (int i = 1; i <= cyc; i++) begin
            @(posedge core_clk);
            if (wdt_reset_req === 1'b1 && t_rst < 0) t_rst = i;
            if (wake_req === 1'b1 && t_wake < 0) t_wake = i;
        end
    endtask

    task automatic clear_req(input logic a, input logic [3:0] g);
        @(posedge core_clk);
        req_clear <= 1'b1;
        use_arm   <= a;
        gap       <= g;
        @(posedge core_clk);
        req_clear <= 1'b0;
    endtask

    task automatic setup(input logic [7:0] c1);
        apb(1'b1, IDX_CTRL1, {24'h0, c1});
        apb(1'b1, IDX_CTRL0, 32'h1);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(34432));
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        por  <= 1'b0;
        apb(1'b0, IDX_CTRL0, 32'h0);
        chk(rd, {26'h0, PS_DEFAULT, 1'b0});
        apb(1'b0, IDX_CTRL1, 32'h0);
        chk(rd, {25'h0, CS_LF, 1'b0, cfg_window_sel});
        apb(1'b0, IDX_CAUSE, 32'h0);
        chk(rd, 32'hf);
        apb(1'b0, 12'h812, 32'h0);
        chk({31'h0, perr}, 32'h1);
        setup(8'h07);
        watch(400);
        chk(t_rst > PER - 16 && t_rst < PER + 24, 1);
        apb(1'b0, IDX_CAUSE, 32'h0);
        chk(rd[CAUSE_RW_BIT], 0);
        dev_reset();
        setup(8'h17);
        watch(700);
        chk(t_rst > 2 * PER - 32 && t_rst < 2 * PER + 48, 1);
        dev_reset();
        apb(1'b1, IDX_CTRL0, 32'h0);
        watch(600);
        chk(t_rst, -1);
        watchdog_mode_cfg <= MODE_OFF;
        dev_reset();
        setup(8'h07);
        watch(600);
        chk(t_rst, -1);
        watchdog_mode_cfg <= MODE_SW;
        for (int w = 0; w < 7; w++) begin
            dev_reset();
            setup(8'(w));
            repeat ((7 - w) * 32 - 14) @(posedge core_clk);
            clear_req(1'b1, 4'h0);
            watch(8);
            chk(t_rst > 0, 1);
            apb(1'b0, IDX_CAUSE, 32'h0);
            chk(rd[CAUSE_WV_BIT], 0);
            dev_reset();
            setup(8'(w));
            repeat ((7 - w) * 32 + 18) @(posedge core_clk);
            clear_req(1'b1, 4'h0);
            watch(8);
            chk(t_rst, -1);
        end
        apb(1'b1, IDX_CAUSE, 32'h1);
        apb(1'b0, IDX_CAUSE, 32'h0);
        chk(rd[CAUSE_WV_BIT], 1);
        dev_reset();
        setup(8'h03);
        repeat (180) @(posedge core_clk);
        clear_req(1'b0, 4'h0);
        watch(8);
        chk(t_rst > 0, 1);
        // A fixed window ignores the software field written by setup.
        cfg_window_sel <= 3'h3;
        dev_reset();
        setup(8'h07);
        repeat (60) @(posedge core_clk);
        clear_req(1'b1, 4'h0);
        watch(8);
        chk(t_rst > 0, 1);
        cfg_window_sel <= WIN_SW_SEL;
        // Code 00001 doubles the period; a reserved code gives the minimum.
        for (int p = 0; p < 2; p++) begin
            int e;
            e = (2 - p) * PER;
            dev_reset();
            apb(1'b1, IDX_CTRL0, p ? 32'h27 : 32'h3);
            watch(700);
            chk(t_rst > e - 16 && t_rst < e + 32, 1);
        end
        // A low enable freezes the count, which resumes afterwards.
        dev_reset();
        setup(8'h07);
        ce <= 1'b0;
        watch(300);
        chk(t_rst, -1);
        ce <= 1'b1;
        watch(300);
        chk(t_rst > PER - 16 && t_rst < PER + 24, 1);
        dev_reset();
        setup(8'h07);
        for (int i = 0; i < 12; i++) begin
            watch($urandom_range(20, 200));
            chk(t_rst, -1);
            clear_req(1'($urandom), 4'($urandom_range(0, 3)));
        end
        for (int k = 0; k < 2; k++) begin
            if (k == 0) osc_startup_timer <= 1'b1;
            else osc_fail <= 1'b1;
            watch(600);
            chk(t_rst, -1);
            osc_startup_timer <= 1'b0;
            osc_fail <= 1'b0;
            watch(300);
            chk(t_rst > PER - 16 && t_rst < PER + 24, 1);
        end
        watchdog_mode_cfg <= MODE_NOSLEEP;
        dev_reset();
        setup(8'h07);
        sleep_active <= 1'b1;
        watch(600);
        chk(t_rst + t_wake, -2);
        sleep_active <= 1'b0;
        watch(400);
        chk(t_rst > PER - 16 && t_rst < PER + 24, 1);
        watchdog_mode_cfg <= MODE_ON;
        cfg_prescale_sel <= PS_MIN;
        dev_reset();
        apb(1'b1, IDX_CTRL0, 32'h3e);
        apb(1'b0, IDX_CTRL0, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, IDX_TMR, 32'h0);
        chk(rd[TMR_ARM_BIT], 1);
        // Set every cause flag so the sleep time-out must clear timeout_n_flag and powerdown_n_flag.
        apb(1'b1, IDX_CAUSE, 32'hf);
        sleep_active <= 1'b1;
        watch(400);
        chk(t_rst, -1);
        chk(t_wake > PER - 16 && t_wake < PER + 24, 1);
        chk({timeout_n_flag, powerdown_n_flag}, 0);
        sleep_active <= 1'b0;
        give_verdict();
    end
endmodule

`default_nettype wire

/* dv/wwd_core_model.sv */
`timescale 1ns/1ns
`default_nettype none

module wwd_core_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // Bench requests
    input  wire logic       req_clear,
    input  wire logic       use_arm,
    input  wire logic [3:0] gap,
    // Strobes to the watchdog
    output logic            clear_command,
    output logic            arm_read
);
    logic       pend_q;
    logic [3:0] wait_q;

    // ------------------------------------------------------------
    // Clear sequence, optionally armed and delayed
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        clear_command <= 1'b0;
        arm_read      <= 1'b0;
        if (srst) begin
            pend_q <= 1'b0;
            wait_q <= 4'h0;
        end else if (pend_q) begin
            if (wait_q == 4'h0) begin
                clear_command <= 1'b1;
                pend_q        <= 1'b0;
            end else begin
                wait_q <= wait_q - 4'h1;
            end
        end else if (req_clear) begin
            arm_read      <= use_arm;
            clear_command <= !use_arm;
            pend_q        <= use_arm;
            wait_q        <= gap;
        end
    end
endmodule

`default_nettype wire
